// >>> logic/epm_bank.sv
// Purpose: page-4 status bank with error counters and reporting latches
// Assumes: host port synchronous to clk_i; events are one-cycle strobes
// Notes:   read data registered, valid the cycle after the read strobe
module epm_bank (
	// clock and reset
	input  wire logic                clk_i,
	input  wire logic                reset_i,
	input  wire logic                ce_i,
	// host register port
	input  wire logic [7:0]          page_i,
	input  wire logic [4:0]          addr_i,
	input  wire logic                rd_i,
	input  wire logic                wr_i,
	input  wire logic [7:0]          wdata_i,
	output logic [7:0]               rdata_o,
	output logic                     rvalid_o,
	// receive path events
	input  wire logic                seq_err_i,
	input  wire logic                submf_i,
	input  wire logic                irq_raise_i,
	input  wire logic [7:0]          irq_category_code_i,
	input  wire logic                far_end_block_i,
	input  wire logic                bipolar_viol_i,
	input  wire logic                crc_block_err_i,
	input  wire logic                frame_tick_i,
	input  wire logic                sync_lost_i,
	input  wire logic [1:0]          align_bit_errs_i,
	input  wire logic                align_word_i,
	input  wire logic                rai_bit_i,
	input  wire logic                e_bit_i,
	input  wire logic [epm_pkg::ALM_RAI:epm_pkg::ALM_SLIP] alarm_evt_i,
	// jitter buffer pointers
	input  wire logic [epm_pkg::JIT_PTR_W-1:0] jit_fill_i,
	input  wire logic                jit_read_i,
	output logic                     jit_slow_o,
	output logic                     jit_fast_o
);
	import epm_pkg::*;

	////////////////////////////////////////////////////////////////
	// address decode
	logic sel, rd_hit, wr_hit;
	assign sel    = (page_i == PAGE_STATUS) && addr_i[4];
	assign rd_hit = ce_i && sel && rd_i;
	assign wr_hit = ce_i && sel && wr_i;

	function automatic logic hit(input logic [4:0] a, input logic [4:0] want);
		hit = (a == want);
	endfunction : hit

	// fill level inside the low or high guard band of the jitter buffer
	function automatic logic fill_low(input logic [JIT_PTR_W-1:0] f);
		fill_low = f < JIT_PTR_W'(JIT_MARGIN);
	endfunction : fill_low

	function automatic logic fill_high(input logic [JIT_PTR_W-1:0] f);
		fill_high = f > JIT_PTR_W'((1 << JIT_PTR_W) - 1 - JIT_MARGIN);
	endfunction : fill_high

	// read-clear latch; an event arriving with the clearing read survives
	function automatic logic [7:0] rc_latch(input logic [7:0] cur, input logic clr, input logic [7:0] evt);
		rc_latch = (clr ? ZERO8 : cur) | evt;
	endfunction : rc_latch

	////////////////////////////////////////////////////////////////
	// counters
	logic [W8-1:0]  seq_err_count, seq_interval_count, jitter_margin_count;
	logic [W8-1:0]  sync_loss_count, align_bit_err_count, errored_align_count;
	logic [W10-1:0] far_end_block_cnt, crc_block_cnt;
	logic [W16-1:0] bipolar_viol_cnt;
	logic [7:0]     wrap;
	logic           seq_wr, sync_q, sync_clr, jit_near, jit_near_q, bit_inc;
	logic [W8-1:0]  bit_err_next;
	logic           bit_wrap_q;

	assign seq_wr   = wr_hit && hit(addr_i, A_SEQ_ERR);
	assign sync_clr = sync_lost_i && !sync_q && frame_tick_i;
	assign jit_near = fill_low(jit_fill_i) || fill_high(jit_fill_i);

	// framer sync state sampled once per frame
	always_ff @(posedge clk_i) begin
		if (reset_i)
			sync_q <= 1'b0;
		else if (ce_i && frame_tick_i)
			sync_q <= sync_lost_i;
	end

	// jitter margin entry edge
	always_ff @(posedge clk_i) begin
		if (reset_i)
			jit_near_q <= 1'b0;
		else if (ce_i)
			jit_near_q <= jit_near;
	end

	// event counters; only the interval count can be cleared by the host
	epm_counter #(.W(W8)) u_seq (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.ce_i    (ce_i),
		.clear_i (1'b0),
		.inc_i   (seq_err_i),
		.count_o (seq_err_count),
		.wrap_o  (wrap[OVF_SEQ])
	);
	epm_counter #(.W(W8)) u_ivl (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.ce_i    (ce_i),
		.clear_i (seq_wr),
		.inc_i   (submf_i),
		.count_o (seq_interval_count),
		.wrap_o  ()
	);
	epm_counter #(.W(W10)) u_feb (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.ce_i    (ce_i),
		.clear_i (1'b0),
		.inc_i   (far_end_block_i),
		.count_o (far_end_block_cnt),
		.wrap_o  (wrap[OVF_FEB])
	);
	epm_counter #(.W(W8)) u_jit (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.ce_i    (ce_i),
		.clear_i (1'b0),
		.inc_i   (jit_near && !jit_near_q),
		.count_o (jitter_margin_count),
		.wrap_o  (wrap[OVF_JIT])
	);
	epm_counter #(.W(W8)) u_sync (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.ce_i    (ce_i),
		.clear_i (sync_clr),
		.inc_i   (frame_tick_i && sync_lost_i),
		.count_o (sync_loss_count),
		.wrap_o  (wrap[OVF_SYNC])
	);
	epm_counter #(.W(W8)) u_ealn (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.ce_i    (ce_i),
		.clear_i (1'b0),
		.inc_i   (bit_inc),
		.count_o (errored_align_count),
		.wrap_o  (wrap[OVF_EALN])
	);
	epm_counter #(.W(W16)) u_bpv (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.ce_i    (ce_i),
		.clear_i (1'b0),
		.inc_i   (bipolar_viol_i),
		.count_o (bipolar_viol_cnt),
		.wrap_o  (wrap[OVF_BPV])
	);
	epm_counter #(.W(W10)) u_crc (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.ce_i    (ce_i),
		.clear_i (1'b0),
		.inc_i   (crc_block_err_i),
		.count_o (crc_block_cnt),
		.wrap_o  (wrap[OVF_CRC])
	);

	// bit error counter adds up to three errored bits per word
	assign bit_err_next = align_bit_err_count + {6'h00, align_bit_errs_i};
	assign bit_inc      = align_word_i && (align_bit_errs_i != 2'h0);
	// own flop keeps the wrap vector free of mixed drivers
	assign wrap[OVF_BIT] = bit_wrap_q;
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			align_bit_err_count <= ZERO8;
			bit_wrap_q          <= 1'b0;
		end else if (ce_i) begin
			bit_wrap_q <= bit_inc && (bit_err_next < align_bit_err_count);
			if (bit_inc)
				align_bit_err_count <= bit_err_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// jitter read clock steering while inside the margin
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			jit_slow_o <= 1'b0;
			jit_fast_o <= 1'b0;
		end else if (ce_i) begin
			jit_slow_o <= fill_low(jit_fill_i);
			jit_fast_o <= fill_high(jit_fill_i);
		end
	end

	////////////////////////////////////////////////////////////////
	// interrupt category vector
	logic [7:0] irq_code_q;
	always_ff @(posedge clk_i) begin
		if (reset_i)
			irq_code_q <= ZERO8;
		else if (ce_i && irq_raise_i)
			irq_code_q <= irq_category_code_i;
	end

	////////////////////////////////////////////////////////////////
	// overflow and alarm latches; set wins over the read clear
	logic [7:0] ovf_q, alarm_q;
	always_ff @(posedge clk_i) begin
		if (reset_i)
			ovf_q <= ZERO8;
		else if (ce_i)
			ovf_q <= rc_latch(ovf_q, rd_hit && hit(addr_i, A_OVF_LATCH), wrap);
	end

	always_ff @(posedge clk_i) begin
		if (reset_i)
			alarm_q <= ZERO8;
		else if (ce_i)
			alarm_q <= rc_latch(alarm_q, rd_hit && hit(addr_i, A_ALARM_LATCH), {alarm_evt_i, 1'b0});
	end

	////////////////////////////////////////////////////////////////
	// remote alarm with continuous crc timing
	logic [TMR_W-1:0] alarm_tmr;
	logic             crc_long_q, crc_win_q, alarm_cond;
	assign alarm_cond = rai_bit_i && !e_bit_i;
	always_ff @(posedge clk_i) begin
		if (reset_i)
			alarm_tmr <= '0;
		else if (ce_i) begin
			if (!alarm_cond)
				alarm_tmr <= '0;
			else if (alarm_tmr <= TMR_W'(ALARM_MAX_CYC))
				alarm_tmr <= alarm_tmr + 1'b1;    // stops just past the long limit
		end
	end

	// long flag is a live status; window flag latches and clears on read
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			crc_long_q <= 1'b0;
			crc_win_q  <= 1'b0;
		end else if (ce_i) begin
			crc_long_q <= alarm_cond && (alarm_tmr > TMR_W'(ALARM_MIN_CYC));
			crc_win_q  <= (rd_hit && hit(addr_i, A_ALARM_CRC) ? 1'b0 : crc_win_q)
				| (alarm_cond && (alarm_tmr > TMR_W'(ALARM_MIN_CYC))
				&& (alarm_tmr < TMR_W'(ALARM_MAX_CYC)));
		end
	end

	////////////////////////////////////////////////////////////////
	// low-byte snapshots taken when the high part is read
	logic [7:0] feb_snap, bpv_snap, crc_snap;
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			feb_snap <= ZERO8;
			bpv_snap <= ZERO8;
			crc_snap <= ZERO8;
		end else if (rd_hit) begin
			if (hit(addr_i, A_FEB_HI))
				feb_snap <= far_end_block_cnt[7:0];
			if (hit(addr_i, A_BPV_HI))
				bpv_snap <= bipolar_viol_cnt[7:0];
			if (hit(addr_i, A_CRC_HI))
				crc_snap <= crc_block_cnt[7:0];
		end
	end

	////////////////////////////////////////////////////////////////
	// read mux, registered; unused bits read zero
	logic [7:0] rmux;
	always_comb begin
		case (addr_i)
			A_SEQ_ERR:     rmux = seq_err_count;
			A_SEQ_IVL:     rmux = seq_interval_count;
			A_IRQ_CODE:    rmux = irq_code_q;
			A_FEB_HI:      rmux = {6'h00, far_end_block_cnt[9:8]};
			A_FEB_LO:      rmux = feb_snap;
			A_JIT_MARGIN:  rmux = jitter_margin_count;
			A_OVF_LATCH:   rmux = ovf_q;
			A_SYNC_LOSS:   rmux = sync_loss_count;
			A_ALIGN_BIT:   rmux = align_bit_err_count;
			A_ALARM_CRC:   rmux = {6'h00, crc_win_q, crc_long_q};
			A_ERR_ALIGN:   rmux = errored_align_count;
			A_ALARM_LATCH: rmux = alarm_q;
			A_BPV_HI:      rmux = bipolar_viol_cnt[15:8];
			A_BPV_LO:      rmux = bpv_snap;
			A_CRC_HI:      rmux = {6'h00, crc_block_cnt[9:8]};
			A_CRC_LO:      rmux = crc_snap;
			default:       rmux = ZERO8;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rdata_o  <= ZERO8;
			rvalid_o <= 1'b0;
		end else if (ce_i) begin
			rvalid_o <= rd_hit;
			if (rd_hit)
				rdata_o <= rmux;
		end
	end
endmodule : epm_bank

// >>> logic/epm_pkg.sv
// Purpose: constants for the page-4 performance monitor bank
// Assumes: 8-bit register port, 5-bit in-page address
// Notes:   shared by the bank, the host model, the checker and the testbench
package epm_pkg;
	localparam logic [7:0] PAGE_STATUS   = 8'h04;
	localparam logic [4:0] A_SEQ_ERR     = 5'h10;
	localparam logic [4:0] A_SEQ_IVL     = 5'h11;
	localparam logic [4:0] A_IRQ_CODE    = 5'h12;
	localparam logic [4:0] A_FEB_HI      = 5'h13;
	localparam logic [4:0] A_FEB_LO      = 5'h14;
	localparam logic [4:0] A_JIT_MARGIN  = 5'h15;
	localparam logic [4:0] A_OVF_LATCH   = 5'h16;
	localparam logic [4:0] A_SYNC_LOSS   = 5'h17;
	localparam logic [4:0] A_ALIGN_BIT   = 5'h18;
	localparam logic [4:0] A_ALARM_CRC   = 5'h19;
	localparam logic [4:0] A_ERR_ALIGN   = 5'h1A;
	localparam logic [4:0] A_ALARM_LATCH = 5'h1B;
	localparam logic [4:0] A_BPV_HI      = 5'h1C;
	localparam logic [4:0] A_BPV_LO      = 5'h1D;
	localparam logic [4:0] A_CRC_HI      = 5'h1E;
	localparam logic [4:0] A_CRC_LO      = 5'h1F;
	// overflow latch bit positions
	localparam int OVF_SEQ   = 7;
	localparam int OVF_FEB   = 6;
	localparam int OVF_JIT   = 5;
	localparam int OVF_SYNC  = 4;
	localparam int OVF_BIT   = 3;
	localparam int OVF_EALN  = 2;
	localparam int OVF_BPV   = 1;
	localparam int OVF_CRC   = 0;
	// alarm latch bit positions, bit 0 unused; then the alarm-crc register flag bits
	localparam int ALM_RAI   = 7;
	localparam int ALM_AIS   = 6;
	localparam int ALM_SLOT16_ALL_ONES_ALARM = 5;
	localparam int ALM_LOS   = 4;
	localparam int ALM_AUX_PATTERN_ALARM  = 3;
	localparam int ALM_MULTIFRAME_ALARM = 2;
	localparam int ALM_SLIP  = 1;
	localparam int CRC_WIN_BIT  = 1;
	localparam int CRC_LONG_BIT = 0;
	// counter widths
	localparam int W8  = 8;
	localparam int W10 = 10;
	localparam int W16 = 16;
	// alarm-with-crc timing
	localparam int CLK_MHZ      = 250;
	localparam int ALARM_MIN_MS = 10;
	localparam int ALARM_MAX_MS = 450;
	localparam int ALARM_MIN_CYC = ALARM_MIN_MS * 1000 * CLK_MHZ;
	localparam int ALARM_MAX_CYC = ALARM_MAX_MS * 1000 * CLK_MHZ;
	localparam int TMR_W = 27;
	// jitter buffer margin
	localparam int JIT_MARGIN = 4;
	localparam int JIT_PTR_W  = 5;
	localparam logic [7:0] ZERO8 = 8'h00;
endpackage : epm_pkg

// >>> logic/epm_counter.sv
// Purpose: saturating-free wrap counter with overflow pulse
// Assumes: one increment per enabled clock at most
// Notes:   width set per instance
module epm_counter #(
	parameter int W = 8
) (
	// clock and control
	input  wire logic         clk_i,
	input  wire logic         reset_i,
	input  wire logic         ce_i,
	input  wire logic         clear_i,
	input  wire logic         inc_i,
	// result
	output logic [W-1:0]      count_o,
	output logic              wrap_o
);
	////////////////////////////////////////////////////////////////
	// count wraps to zero past its top value; clear beats increment
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			count_o <= '0;
			wrap_o  <= 1'b0;
		end else if (ce_i) begin
			wrap_o <= inc_i && !clear_i && (&count_o);
			if (clear_i)
				count_o <= '0;
			else if (inc_i)
				count_o <= count_o + 1'b1;
		end
	end
endmodule : epm_counter

// >>> verification/epm_host.sv
// Purpose: host processor model on the paged register port
// Assumes: one access at a time, one-cycle strobes
// Notes:   released lines show the inverted last value
module epm_host (
	// clock
	input  wire logic       clk_i,
	// answer from the bank
	input  wire logic       rvalid_i,
	input  wire logic [7:0] rdata_i,
	// request lines
	output logic      [7:0] page_o,
	output logic      [4:0] addr_o,
	output logic            rd_o,
	output logic            wr_o,
	output logic      [7:0] wdata_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import epm_pkg::*;
	// idle bus at time zero
	initial begin
		{page_o, addr_o, rd_o, wr_o, wdata_o} = 23'h000000;
	end
	////////////////////////////////////////
	// read; no answer within three edges leaves d unknown
	task automatic rd(input logic [7:0] p, input logic [4:0] a, output logic [7:0] d);
		d = 8'hXX;
		@(posedge clk_i);
		{page_o, addr_o, rd_o} <= {p, a, 1'b1};
		@(posedge clk_i);
		{page_o, addr_o, rd_o} <= {~p, ~a, 1'b0};
		for (int i = 0; i < 3; i++) begin
			@(posedge clk_i);
			if (rvalid_i === 1'b1) begin
				d = rdata_i;
				break;
			end
		end
	endtask : rd
	// a write to the error count opens a new interval
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk_i);
		{page_o, addr_o, wdata_o, wr_o} <= {PAGE_STATUS, a, d, 1'b1};
		@(posedge clk_i);
		{page_o, addr_o, wdata_o, wr_o} <= {~PAGE_STATUS, ~a, ~d, 1'b0};
	endtask : wr
endmodule : epm_host

// >>> verification/epm_bank_assertions.sv
// Purpose: port checks for the status bank
// Assumes: one clock, sync reset
// Notes:   bound into every epm_bank
module epm_bank_chk (
	// clock and reset
	input wire logic       clk_i,
	input wire logic       reset_i,
	// host port
	input wire logic       ce_i,
	input wire logic [7:0] page_i,
	input wire logic [4:0] addr_i,
	input wire logic       rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic       rvalid_o,
	// events and jitter
	input wire logic       irq_raise_i,
	input wire logic [7:0] irq_category_code_i,
	input wire logic [epm_pkg::JIT_PTR_W-1:0] jit_fill_i,
	input wire logic       jit_slow_o,
	input wire logic       jit_fast_o
);
	import epm_pkg::*;
	localparam int HI = (1 << JIT_PTR_W) - 1 - JIT_MARGIN;
	logic tk;
	logic crd;
	// taken reads; helpers keep sequences out of logical and
	assign tk = ce_i && rd_i && page_i == PAGE_STATUS && addr_i[4];
	assign crd = tk && addr_i == A_IRQ_CODE && !irq_raise_i;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	////////////////////////////////////////
	sequence s_raise_read; ce_i && irq_raise_i ##1 crd; endsequence
	sequence s_two_reads; crd ##1 (!irq_raise_i && !tk) [*2] ##1 crd; endsequence
	property p_answer; tk |=> rvalid_o; endproperty
	property p_idle; ce_i && !tk |=> !rvalid_o; endproperty
	property p_hold; !(ce_i && rd_i) |=> $stable(rdata_o); endproperty
	property p_irq; s_raise_read |=> rdata_o == $past(irq_category_code_i, 2); endproperty
	property p_keep; s_two_reads |=> rdata_o == $past(rdata_o); endproperty
	property p_slow; ce_i && jit_fill_i < JIT_MARGIN |=> jit_slow_o && !jit_fast_o; endproperty
	property p_fast; ce_i && jit_fill_i > HI |=> jit_fast_o && !jit_slow_o; endproperty
	property p_mid; ce_i && jit_fill_i >= JIT_MARGIN && jit_fill_i <= HI |=> !jit_slow_o && !jit_fast_o; endproperty
	a_answer: assert property (p_answer) else $error("read not answered");
	a_idle: assert property (p_idle) else $error("stray read valid");
	a_hold: assert property (p_hold) else $error("read data moved");
	a_irq: assert property (p_irq) else $error("wrong vector code");
	a_keep: assert property (p_keep) else $error("vector code moved");
	a_slow: assert property (p_slow) else $error("slow not set");
	a_fast: assert property (p_fast) else $error("fast not set");
	a_mid: assert property (p_mid) else $error("rate adjust outside margin");
endmodule : epm_bank_chk
bind epm_bank epm_bank_chk i_epm_bank_chk (.clk_i, .reset_i, .ce_i, .page_i, .addr_i, .rd_i, .rdata_o,
	.rvalid_o, .irq_raise_i, .irq_category_code_i, .jit_fill_i, .jit_slow_o, .jit_fast_o);

// >>> verification/epm_testbench.sv
// Purpose: directed register tests for the status bank
// Assumes: host model drives the register port
// Notes:   the 10/450 ms alarm timers are too long to run here
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import epm_pkg::*;
	`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
		$display("[FAIL] t=%0t got=%0h exp=%0h", $time, g, e); end end
	logic       clk_i, reset_i, ce_i, rd, wr, rvalid, irq, ft, sl, aw, slow, fast, rai, eb;
	logic [7:0] page, wdata, rdata, code;
	logic [4:0] addr, ev, jf;
	logic [1:0] ae;
	logic [7:1] al;
	int         fail_count, n_checks;
	// ev bits: error, interval, far end, bipolar, crc
	epm_bank i_epm_bank (.clk_i, .reset_i, .ce_i, .page_i(page), .addr_i(addr), .rd_i(rd), .wr_i(wr),
		.wdata_i(wdata), .rdata_o(rdata), .rvalid_o(rvalid), .seq_err_i(ev[4]), .submf_i(ev[3]),
		.irq_raise_i(irq), .irq_category_code_i(code), .far_end_block_i(ev[2]), .bipolar_viol_i(ev[1]),
		.crc_block_err_i(ev[0]), .frame_tick_i(ft), .sync_lost_i(sl), .align_bit_errs_i(ae),
		.align_word_i(aw), .rai_bit_i(rai), .e_bit_i(eb), .alarm_evt_i(al), .jit_fill_i(jf),
		.jit_read_i(1'b0), .jit_slow_o(slow), .jit_fast_o(fast));
	epm_host u_host (.clk_i, .rvalid_i(rvalid), .rdata_i(rdata), .page_o(page), .addr_o(addr),
		.rd_o(rd), .wr_o(wr), .wdata_o(wdata));
	////////////////////////////////////////
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	task automatic rdc(input logic [7:0] p, input logic [4:0] a, input logic [7:0] e);
		logic [7:0] d;
		u_host.rd(p, a, d);
		`CHK(d, e)
	endtask : rdc
	// back-to-back one-cycle events, n of them
	task automatic burst(input logic [4:0] m, input int n);
		@(posedge clk_i);
		ev <= m;
		repeat (n) @(posedge clk_i);
		ev <= 5'h00;
	endtask : burst
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge clk_i);
			ft <= 1'b1;
			@(posedge clk_i);
			ft <= 1'b0;
		end
	endtask : tick
	task automatic summarize;
		$display("checks=%0d mismatches=%0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : summarize
	// hang guard, well beyond the few thousand cycles needed
	initial begin
		repeat (20000) @(posedge clk_i);
		fail_count++;
		summarize();
	end
	////////////////////////////////////////
	initial begin
		{reset_i, ce_i, irq, ft, sl, aw, rai, eb} = 8'hC0;
		{ev, ae, al, code} = 22'h000000;
		jf = 5'h10;
		repeat (12) @(posedge clk_i);
		reset_i <= 1'b0;
		for (int a = 16; a < 32; a++) rdc(PAGE_STATUS, 5'(a), 8'h00);
		rdc(8'h05, A_SEQ_ERR, 8'hXX);
		rdc(PAGE_STATUS, 5'h05, 8'hXX);
		burst(5'h10, 3);
		burst(5'h08, 2);
		rdc(PAGE_STATUS, A_SEQ_ERR, 8'h03);
		rdc(PAGE_STATUS, A_SEQ_IVL, 8'h02);
		u_host.wr(A_SEQ_ERR, 8'h55);
		rdc(PAGE_STATUS, A_SEQ_IVL, 8'h00);
		rdc(PAGE_STATUS, A_SEQ_ERR, 8'h03);
		burst(5'h10, 253);
		rdc(PAGE_STATUS, A_SEQ_ERR, 8'h00);
		rdc(PAGE_STATUS, A_OVF_LATCH, 8'h80);
		rdc(PAGE_STATUS, A_OVF_LATCH, 8'h00);
		burst(5'h04, 1025);
		burst(5'h02, 291);
		burst(5'h01, 767);
		rdc(PAGE_STATUS, A_FEB_HI, 8'h00);
		rdc(PAGE_STATUS, A_FEB_LO, 8'h01);
		rdc(PAGE_STATUS, A_BPV_HI, 8'h01);
		rdc(PAGE_STATUS, A_BPV_LO, 8'h23);
		rdc(PAGE_STATUS, A_CRC_HI, 8'h02);
		burst(5'h01, 1);
		rdc(PAGE_STATUS, A_CRC_LO, 8'hFF);
		rdc(PAGE_STATUS, A_OVF_LATCH, 8'h40);
		// vector raised one edge before the read, code changed after
		@(posedge clk_i);
		{irq, code} <= {1'b1, 8'hA5};
		fork
			rdc(PAGE_STATUS, A_IRQ_CODE, 8'hA5);
			begin
				@(posedge clk_i);
				{irq, code} <= {1'b0, 8'h3C};
			end
		join
		rdc(PAGE_STATUS, A_IRQ_CODE, 8'hA5);
		// fill enters low margin, leaves, enters high margin
		@(posedge clk_i);
		jf <= 5'h02;
		repeat (2) @(posedge clk_i);
		`CHK(slow, 1'b1)
		jf <= 5'h10;
		repeat (2) @(posedge clk_i);
		jf <= 5'h1E;
		repeat (2) @(posedge clk_i);
		`CHK(fast, 1'b1)
		jf <= 5'h10;
		rdc(PAGE_STATUS, A_JIT_MARGIN, 8'h02);
		// second loss of sync restarts the count
		sl <= 1'b1;
		tick(4);
		sl <= 1'b0;
		tick(1);
		sl <= 1'b1;
		tick(3);
		rdc(PAGE_STATUS, A_SYNC_LOSS, 8'h02);
		for (int i = 2; i >= 0; i--) begin
			@(posedge clk_i);
			{aw, ae} <= {1'b1, 2'(i)};
		end
		@(posedge clk_i);
		aw <= 1'b0;
		rdc(PAGE_STATUS, A_ALIGN_BIT, 8'h03);
		rdc(PAGE_STATUS, A_ERR_ALIGN, 8'h02);
		@(posedge clk_i);
		al <= 7'h7F;
		@(posedge clk_i);
		al <= 7'h00;
		rdc(PAGE_STATUS, A_ALARM_LATCH, 8'hFE);
		rdc(PAGE_STATUS, A_ALARM_LATCH, 8'h00);
		// clock enable low freezes the error count
		ce_i <= 1'b0;
		burst(5'h10, 4);
		ce_i <= 1'b1;
		rdc(PAGE_STATUS, A_SEQ_ERR, 8'h00);
		// a short remote alarm stays far below the 10 ms mark
		{rai, eb} <= 2'b10;
		repeat (64) @(posedge clk_i);
		rdc(PAGE_STATUS, A_ALARM_CRC, 8'h00);
		{rai, eb} <= 2'b01;
		summarize();
	end
endmodule : testbench
